// ===== cwf_pkg.sv
// Constants for the wakeup frame filter reference block.
// Assumes a 12-bit Wishbone byte address and 32-bit data.
package cwf_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] CWF_OFF_EID = 12'hb0c;
    localparam logic [11:0] CWF_OFF_EDLC = 12'hb10;
    localparam logic [11:0] CWF_OFF_EDL0 = 12'hb14;
    localparam logic [11:0] CWF_OFF_EDL1 = 12'hb18;
    localparam logic [11:0] CWF_OFF_IFE = 12'hb1c;
    localparam logic [11:0] CWF_OFF_DH0 = 12'hb20;
    localparam logic [11:0] CWF_OFF_DH1 = 12'hb24;
    localparam logic [11:0] CWF_OFF_CTRL = 12'hb28;
    localparam logic [11:0] CWF_OFF_STAT = 12'hb2c;

    // ------------------------------------------------------------
    // Word indexes inside the register memory
    // ------------------------------------------------------------
    localparam logic [2:0] CWF_IDX_EID = 3'h0;
    localparam logic [2:0] CWF_IDX_EDLC = 3'h1;
    localparam logic [2:0] CWF_IDX_EDL0 = 3'h2;
    localparam logic [2:0] CWF_IDX_EDL1 = 3'h3;
    localparam logic [2:0] CWF_IDX_IFE = 3'h4;
    localparam logic [2:0] CWF_IDX_DH0 = 3'h5;
    localparam logic [2:0] CWF_IDX_DH1 = 3'h6;
    localparam logic [2:0] CWF_IDX_CTRL = 3'h7;

    // ------------------------------------------------------------
    // Reset values, index 7 leftmost
    // ------------------------------------------------------------
    localparam logic [31:0] CWF_RST_EDLC = 32'h0000_0008;
    localparam logic [7:0][31:0] CWF_RST_VEC = {32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, CWF_RST_EDLC, 32'h0};

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CWF_FMT_BIT = 30;
    localparam int CWF_TYPE_BIT = 29;
    localparam int CWF_STD_LSB = 18;
    localparam int CWF_LEN_LO_LSB = 16;
    localparam int CWF_LEN_HI_LSB = 0;
    localparam int CWF_SCOPE_LSB = 0;
    localparam int CWF_IDSEL_LSB = 2;
    localparam int CWF_DSEL_LSB = 4;
    localparam int CWF_NEED_LSB = 8;
    localparam int CWF_WAKE_BIT = 16;
    localparam int CWF_CNT_LSB = 8;

    // Comparison kinds shared by identifier and data tests
    typedef enum logic [1:0] {
        CWF_EQ = 2'h0,
        CWF_GE = 2'h1,
        CWF_LE = 2'h2,
        CWF_RANGE = 2'h3
    } cwf_test_t;

    // Bus handshake states, one-hot
    typedef enum logic [3:0] {
        CWF_IDLE = 4'h1,
        CWF_WAIT = 4'h2,
        CWF_LOAD = 4'h4,
        CWF_ACK = 4'h8
    } cwf_bus_t;

endpackage : cwf_pkg

// ===== cwf_regs.sv
// Register memory of the filter references, with registered read.
// Assumes the caller qualifies writes; all words also leave in parallel.
module cwf_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [2:0] wadr_i,
    input wire logic [31:0] wdat_i,
    input wire logic [2:0] radr_i,
    output logic [31:0] rdat_o,
    output logic [7:0][31:0] words_o
);

    typedef struct packed {
        logic [7:0][31:0] mem;
        logic [31:0] rdat;
    } cwf_regs_st_t;

    cwf_regs_st_t s_q;
    cwf_regs_st_t s_d;

    // ------------------------------------------------------------
    // Next state: write port and read register
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (ce_i) begin
            if (we_i) begin
                s_d.mem[wadr_i] = wdat_i;
            end
            s_d.rdat = s_q.mem[radr_i];
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= {cwf_pkg::CWF_RST_VEC, 32'h0};
        end else begin
            s_q <= s_d;
        end
    end

    assign rdat_o = s_q.rdat;
    assign words_o = s_q.mem;

endmodule : cwf_regs

// ===== cwf_top.sv
// Wakeup frame filter: reference registers and the frame comparison.
// Assumes a Wishbone classic master and a frame receiver, both on clk_i.
//
// Implementation choice: the Wishbone slave port.

// Notes on behaviour
// - Reference register writes are ignored unless the controller is inactive.
// - Expected identifier bit 30 selects standard or extended format.
// - Expected identifier bit 29 selects data or remote frame.
// - Identifier field is expected value, or low bound for range test.
// - Standard frames compare identifier bits 28 to 18 only.
// - Length register: low bound bits 19:16, high bound 3:0, reset 8.
// - Two data words hold bytes 0 to 7, byte 0 in the top lane.
// - Data bytes are expected value, or low bound for range test.
// - Mask bit 30 enables the frame format comparison.
// - Mask bit 29 enables the frame type comparison.
// - Equality test: each mask bit enables one identifier bit.
// - Range test: mask field is the identifier high bound.
// - Single-bound identifier tests ignore the mask field.
// - Identifier test: equal, at least, at most, or within range.
// - Data test: equal, at least, at most, or within range.
// - Scope picks data and length checks, optionally counting matches.
// - Data high bytes are masks, high bounds, or unused.
module cwf_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic inactive_mode_i,
    input wire logic frm_valid_i,
    input wire logic frm_ide_i,
    input wire logic frm_rtr_i,
    input wire logic [28:0] frm_id_i,
    input wire logic [3:0] frm_dlc_i,
    input wire logic [63:0] frm_data_i,
    output logic match_o,
    output logic wakeup_o
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Standard frames keep only the top eleven identifier bits
    function automatic logic [63:0] cwf_cut(input logic [28:0] id,
                                            input logic ext);
        logic [28:0] m;
        m = id;
        if (!ext) begin
            m[cwf_pkg::CWF_STD_LSB-1:0] = '0;
        end
        return {35'h0, m};
    endfunction : cwf_cut

    // One comparison of the four kinds, shared by identifier and data
    function automatic logic cwf_test(input logic [63:0] rx,
                                      input logic [63:0] lo,
                                      input logic [63:0] hi,
                                      input logic [1:0] sel);
        logic ok;
        ok = 1'b0;
        case (cwf_pkg::cwf_test_t'(sel))
            cwf_pkg::CWF_EQ: ok = ((rx ^ lo) & hi) == 64'h0;
            cwf_pkg::CWF_GE: ok = rx >= lo;
            cwf_pkg::CWF_LE: ok = rx <= lo;
            cwf_pkg::CWF_RANGE: ok = (rx >= lo) && (rx <= hi);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : cwf_test

    // Byte address to {hit, memory index}
    function automatic logic [3:0] cwf_decode(input logic [11:0] adr);
        logic [11:0] off;
        logic hit;
        off = adr - cwf_pkg::CWF_OFF_EID;
        hit = (adr >= cwf_pkg::CWF_OFF_EID) &&
              (adr <= cwf_pkg::CWF_OFF_CTRL) && (adr[1:0] == 2'h0);
        return {hit, off[4:2]};
    endfunction : cwf_decode

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        cwf_pkg::cwf_bus_t st;
        logic [31:0] dat;
        logic ack;
        logic match;
        logic wake;
        logic wflag;
        logic [7:0] cnt;
    } cwf_state_t;

    cwf_state_t s_q;
    cwf_state_t s_d;

    logic [7:0][31:0] w;
    logic [31:0] rf_rdat;
    logic rf_we;
    logic [3:0] dec;
    logic req;
    logic wr_full;
    logic stat_hit;
    logic [31:0] stat_word;

    // ------------------------------------------------------------
    // Register memory
    // ------------------------------------------------------------
    cwf_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .we_i(rf_we),
        .wadr_i(dec[2:0]),
        .wdat_i(wb_dat_i),
        .radr_i(dec[2:0]),
        .rdat_o(rf_rdat),
        .words_o(w)
    );

    // ------------------------------------------------------------
    // Field views of the reference words
    // ------------------------------------------------------------
    logic exp_fmt;
    logic exp_type;
    logic [28:0] exp_id;
    logic fmt_mask;
    logic type_mask;
    logic [28:0] id_hi;
    logic [3:0] len_lo;
    logic [3:0] len_hi;
    logic [63:0] data_lo;
    logic [63:0] data_hi;
    logic [1:0] scope;
    logic [1:0] id_sel;
    logic [1:0] data_sel;
    logic [7:0] required_match_count;

    // Fixed bit positions; byte 0 sits in the top lane of word 0
    assign exp_fmt = w[cwf_pkg::CWF_IDX_EID][cwf_pkg::CWF_FMT_BIT];
    assign exp_type = w[cwf_pkg::CWF_IDX_EID][cwf_pkg::CWF_TYPE_BIT];
    assign exp_id = w[cwf_pkg::CWF_IDX_EID][28:0];
    assign fmt_mask = w[cwf_pkg::CWF_IDX_IFE][cwf_pkg::CWF_FMT_BIT];
    assign type_mask = w[cwf_pkg::CWF_IDX_IFE][cwf_pkg::CWF_TYPE_BIT];
    assign id_hi = w[cwf_pkg::CWF_IDX_IFE][28:0];
    assign len_lo = w[cwf_pkg::CWF_IDX_EDLC][cwf_pkg::CWF_LEN_LO_LSB+:4];
    assign len_hi = w[cwf_pkg::CWF_IDX_EDLC][cwf_pkg::CWF_LEN_HI_LSB+:4];
    assign data_lo = {w[cwf_pkg::CWF_IDX_EDL0],
                      w[cwf_pkg::CWF_IDX_EDL1]};
    assign data_hi = {w[cwf_pkg::CWF_IDX_DH0], w[cwf_pkg::CWF_IDX_DH1]};
    assign scope = w[cwf_pkg::CWF_IDX_CTRL][cwf_pkg::CWF_SCOPE_LSB+:2];
    assign id_sel = w[cwf_pkg::CWF_IDX_CTRL][cwf_pkg::CWF_IDSEL_LSB+:2];
    assign data_sel = w[cwf_pkg::CWF_IDX_CTRL][cwf_pkg::CWF_DSEL_LSB+:2];
    assign required_match_count =
        w[cwf_pkg::CWF_IDX_CTRL][cwf_pkg::CWF_NEED_LSB+:8];

    // ------------------------------------------------------------
    // Frame comparison
    // ------------------------------------------------------------
    logic fmt_ok;
    logic type_ok;
    logic id_ok;
    logic len_ok;
    logic data_ok;
    logic hit;
    logic [63:0] rx_id;
    logic [63:0] ref_lo;
    logic [63:0] ref_hi;

    // Received format decides how many identifier bits count
    assign rx_id = cwf_cut(frm_id_i, frm_ide_i);
    assign ref_lo = cwf_cut(exp_id, frm_ide_i);
    assign ref_hi = cwf_cut(id_hi, frm_ide_i);

    // A cleared mask bit makes the received bit irrelevant
    assign fmt_ok = !fmt_mask || (frm_ide_i == exp_fmt);
    assign type_ok = !type_mask || (frm_rtr_i == exp_type);

    // Single-bound kinds never look at the mask field
    assign id_ok = cwf_test(rx_id, ref_lo, ref_hi, id_sel);
    assign data_ok = cwf_test(frm_data_i, data_lo, data_hi,
                              data_sel);
    assign len_ok = (frm_dlc_i >= len_lo) && (frm_dlc_i <= len_hi);

    // Scope bit 0 adds the length and data checks
    assign hit = fmt_ok && type_ok && id_ok &&
                 (!scope[0] || (len_ok && data_ok));

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign dec = cwf_decode(wb_adr_i);
    assign req = wb_cyc_i && wb_stb_i;
    // Partial-lane writes are dropped rather than merged
    assign wr_full = wb_we_i && (wb_sel_i == 4'hf);
    assign stat_hit = (wb_adr_i == cwf_pkg::CWF_OFF_STAT);
    assign stat_word = {15'h0, s_q.wflag, s_q.cnt, 8'h0};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic clr;
        logic wev;
        clr = 1'b0;
        wev = 1'b0;
        s_d = s_q;
        rf_we = 1'b0;
        if (ce_i) begin
            s_d.match = 1'b0;
            // Bus handshake: take, two read cycles, then one ack cycle
            case (s_q.st)
                cwf_pkg::CWF_IDLE: begin
                    if (req) begin
                        s_d.st = cwf_pkg::CWF_WAIT;
                        rf_we = wr_full && dec[3] && inactive_mode_i;
                        clr = wr_full && stat_hit &&
                              wb_dat_i[cwf_pkg::CWF_WAKE_BIT];
                    end
                end
                cwf_pkg::CWF_WAIT: begin
                    s_d.st = cwf_pkg::CWF_LOAD;
                end
                cwf_pkg::CWF_LOAD: begin
                    s_d.st = cwf_pkg::CWF_ACK;
                    s_d.ack = 1'b1;
                    if (dec[3]) begin
                        s_d.dat = rf_rdat;
                    end else if (stat_hit) begin
                        s_d.dat = stat_word;
                    end else begin
                        s_d.dat = 32'h0; // Unmapped reads return zero
                    end
                end
                cwf_pkg::CWF_ACK: begin
                    s_d.st = cwf_pkg::CWF_IDLE;
                    s_d.ack = 1'b0;
                end
                default: begin
                    s_d.st = cwf_pkg::CWF_IDLE;
                    s_d.ack = 1'b0;
                end
            endcase
            // Filtering only while out of the configuration mode
            if (inactive_mode_i) begin
                s_d.cnt = 8'h0;
            end else if (frm_valid_i && hit) begin
                s_d.match = 1'b1;
                if (scope[1]) begin
                    // Counted scope: wake after the programmed number
                    if ((s_q.cnt + 8'h01) >= required_match_count) begin
                        s_d.cnt = 8'h0;
                        wev = 1'b1;
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                    end
                end else begin
                    wev = 1'b1;
                end
            end
            s_d.wake = wev;
            // Set wins over a same-cycle clear
            s_d.wflag = (s_q.wflag && !clr) || wev;
        end
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '{st: cwf_pkg::CWF_IDLE, dat: 32'h0, ack: 1'b0,
                     match: 1'b0, wake: 1'b0, wflag: 1'b0, cnt: 8'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign match_o = s_q.match;
    assign wakeup_o = s_q.wake;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Register contents frozen outside the inactive mode
    AST_WR_LOCK: assert property (
        !inactive_mode_i |=> $stable(w))
        else $error("reference changed outside inactive mode");

    // A partial-lane write leaves every word alone
    AST_FULL_WORD: assert property (
        (s_q.st == cwf_pkg::CWF_IDLE) && req && (wb_sel_i != 4'hf)
        |=> $stable(w))
        else $error("partial write altered a reference");

    // Enabled format compare rejects the wrong format
    AST_FMT: assert property (
        ce_i && frm_valid_i && fmt_mask && (frm_ide_i != exp_fmt)
        |=> !match_o)
        else $error("format mismatch still matched");

    // Enabled type compare rejects the wrong frame type
    AST_TYPE: assert property (
        ce_i && frm_valid_i && type_mask && (frm_rtr_i != exp_type)
        |=> !match_o)
        else $error("frame type mismatch still matched");

    // A masked identifier bit that differs blocks the match
    AST_ID_MASK: assert property (
        ce_i && frm_valid_i && (id_sel == 2'h0) &&
        (((rx_id ^ ref_lo) & ref_hi) != 64'h0)
        |=> !match_o)
        else $error("masked identifier bit ignored");

    // Range test rejects identifiers above the high bound
    AST_ID_RANGE: assert property (
        ce_i && frm_valid_i && (id_sel == 2'h3) && (rx_id > ref_hi)
        |=> !match_o)
        else $error("identifier above high bound matched");

    // Length below the low bound fails when data is in scope
    AST_LEN: assert property (
        ce_i && frm_valid_i && scope[0] && (frm_dlc_i < len_lo)
        |=> !match_o)
        else $error("short length matched");

    // Every match traces to a frame seen outside configuration
    AST_MATCH_CAUSE: assert property (
        match_o |-> $past(frm_valid_i) && !$past(inactive_mode_i))
        else $error("match without a frame");

    // Counted scope wakes only when the count reaches its target
    AST_WAKE_COUNT: assert property (
        wakeup_o && $past(scope[1])
        |-> ($past(s_q.cnt) + 8'h01) >= $past(required_match_count))
        else $error("wakeup before match count reached");

    // Main scenarios
    CV_MATCH_PLAIN: cover property (match_o && (scope == 2'h0));
    CV_WAKE_COUNTED: cover property (wakeup_o && scope[1]);
    CV_REF_WRITE: cover property (rf_we);
    CV_DATA_RANGE: cover property (match_o && scope[0] &&
                                   (data_sel == 2'h3));

endmodule : cwf_top

// ===== cwf_frame_src.sv
// Frame source standing in for the CAN bus side of the wakeup filter.
// Assumes the bench calls send from its own process, synchronous to clk_i.
module cwf_frame_src (
    input wire logic clk_i,
    output logic frm_valid_o,
    output logic frm_ide_o,
    output logic frm_rtr_o,
    output logic [28:0] frm_id_o,
    output logic [3:0] frm_dlc_o,
    output logic [63:0] frm_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    // Idle fields carry junk, so a stale frame never looks valid
    initial begin
        frm_valid_o = 1'h0;
        frm_ide_o = 1'h1;
        frm_rtr_o = 1'h1;
        frm_id_o = 29'h1fff_ffff;
        frm_dlc_o = 4'hf;
        frm_data_o = 64'hffff_ffff_ffff_ffff;
    end

    // ------------------------------------------------------------
    // One received frame, a single-cycle valid pulse
    // ------------------------------------------------------------
    task automatic send(input logic ide, input logic rtr,
                        input logic [28:0] id, input logic [3:0] dlc,
                        input logic [63:0] data);
        @(posedge clk_i);
        frm_valid_o <= 1'h1;
        frm_ide_o <= ide;
        frm_rtr_o <= rtr;
        frm_id_o <= id;
        frm_dlc_o <= dlc;
        frm_data_o <= data;
        @(posedge clk_i);
        // Released fields show the inverse of the last frame
        frm_valid_o <= 1'h0;
        frm_ide_o <= ~ide;
        frm_rtr_o <= ~rtr;
        frm_id_o <= ~id;
        frm_dlc_o <= ~dlc;
        frm_data_o <= ~data;
    endtask : send
endmodule : cwf_frame_src

// ===== cwf_top_tb.sv
// Self-checking bench for the wakeup filter references and comparison.
// Assumes cwf_frame_src drives the frame side; ce_i is a bench signal.
module cwf_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic clk_i, rst_i, ce, inact, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [11:0] wb_adr;
    logic [3:0] wb_sel, frm_dlc;
    logic [31:0] wb_dat, wb_rdat;
    logic frm_valid, frm_ide, frm_rtr, match, wake;
    logic [28:0] frm_id;
    logic [63:0] frm_data;
    int mismatches = 0;
    int checked = 0;
    // Expected hits per test kind over lo-1, lo, lo+1, hi, hi+1
    localparam logic [3:0][4:0] PAT = {5'h0e, 5'h03, 5'h1e, 5'h07};

    cwf_top u_cwf_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .inactive_mode_i(inact),
        .frm_valid_i(frm_valid), .frm_ide_i(frm_ide), .frm_rtr_i(frm_rtr),
        .frm_id_i(frm_id), .frm_dlc_i(frm_dlc), .frm_data_i(frm_data),
        .match_o(match), .wakeup_o(wake));
    cwf_frame_src u_cwf_frame_src (.clk_i(clk_i), .frm_valid_o(frm_valid),
        .frm_ide_o(frm_ide), .frm_rtr_o(frm_rtr), .frm_id_o(frm_id),
        .frm_dlc_o(frm_dlc), .frm_data_o(frm_data));

    initial begin
        clk_i = 1'h0;
        forever #5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        $display("counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // Wishbone classic cycle; waits for ack under a bound
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'h1 && n < 20);
        q = wb_rdat;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (wb_ack !== 1'h1) begin
            mismatches++;
            $display("unexpected at %0t: no ack", $time);
            test_done();
        end
    endtask : wb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, d, 4'hf, q);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, 4'hf, q);
        check(q, exp);
    endtask : rd

    // Programs every reference word, only inside inactive mode
    task automatic prog(input logic [31:0] eid, input logic [31:0] len,
                        input logic [63:0] lo, input logic [31:0] ife,
                        input logic [63:0] hi, input logic [31:0] ctl);
        @(posedge clk_i);
        inact <= 1'h1;
        wr(cwf_pkg::CWF_OFF_EID, eid);
        wr(cwf_pkg::CWF_OFF_EDLC, len);
        wr(cwf_pkg::CWF_OFF_EDL0, lo[63:32]);
        wr(cwf_pkg::CWF_OFF_EDL1, lo[31:0]);
        wr(cwf_pkg::CWF_OFF_IFE, ife);
        wr(cwf_pkg::CWF_OFF_DH0, hi[63:32]);
        wr(cwf_pkg::CWF_OFF_DH1, hi[31:0]);
        wr(cwf_pkg::CWF_OFF_CTRL, ctl);
        @(posedge clk_i);
        inact <= 1'h0;
    endtask : prog

    // Sends one frame and looks at the pulses in the cycle after it
    task automatic fr(input logic ide, input logic rtr, input logic [28:0] id,
                      input logic [3:0] dlc, input logic [63:0] data,
                      input logic m, input logic w);
        u_cwf_frame_src.send(ide, rtr, id, dlc, data);
        #1;
        check({31'h0, match}, {31'h0, m});
        check({31'h0, wake}, {31'h0, w});
    endtask : fr

    // Five values around the low and high bounds, one test kind
    task automatic rt(input logic dat, input logic [1:0] s);
        logic [63:0] lo, hi, v;
        lo = dat ? 64'h1000_0000_0000_0000 : 64'h100;
        hi = dat ? 64'h2000_0000_0000_0000 : 64'h200;
        if (dat)
            prog(32'h0, 32'hf, lo, 32'h0, hi, {26'h0, s, 4'h5});
        else
            prog(lo[31:0], 32'h0, 64'h0, hi[31:0], 64'h0, {28'h0, s, 2'h0});
        for (int k = 0; k < 5; k++) begin
            v = (k < 3) ? lo + 64'(k) - 64'h1 : hi + 64'(k) - 64'h3;
            if (dat)
                fr(1'h1, 1'h0, 29'h0, 4'h3, v, PAT[s][k], PAT[s][k]);
            else
                fr(1'h1, 1'h0, v[28:0], 4'h0, 64'h0, PAT[s][k], PAT[s][k]);
        end
    endtask : rt

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] q;
        rst_i = 1'h1;
        inact = 1'h0;
        ce = 1'h1;
        wb_cyc = 1'h0;
        wb_stb = 1'h0;
        wb_we = 1'h0;
        wb_adr = 12'h0;
        wb_sel = 4'h0;
        wb_dat = 32'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(cwf_pkg::CWF_OFF_EID, 32'h0);
        rd(cwf_pkg::CWF_OFF_EDLC, 32'h8);
        rd(cwf_pkg::CWF_OFF_EDL0, 32'h0);
        rd(cwf_pkg::CWF_OFF_EDL1, 32'h0);
        rd(cwf_pkg::CWF_OFF_IFE, 32'h0);
        rd(12'hb00, 32'h0);
        $display("test reset done");
        // Locked writes outside inactive mode, then a partial write
        wr(cwf_pkg::CWF_OFF_EID, 32'h4123_4567);
        rd(cwf_pkg::CWF_OFF_EID, 32'h0);
        @(posedge clk_i);
        inact <= 1'h1;
        wb(1'h1, cwf_pkg::CWF_OFF_EDLC, 32'h0002_0005, 4'h3, q);
        rd(cwf_pkg::CWF_OFF_EDLC, 32'h8);
        wr(cwf_pkg::CWF_OFF_EDLC, 32'h0002_0005);
        rd(cwf_pkg::CWF_OFF_EDLC, 32'h0002_0005);
        $display("test access done");
        // Masked equality on extended and standard identifiers, format and type
        prog(32'h4123_4567, 32'h0, 64'h0, 32'h7fff_fffe, 64'h0, 32'h0);
        fr(1'h1, 1'h0, 29'h0123_4567, 4'h0, 64'h0, 1'h1, 1'h1);
        fr(1'h1, 1'h0, 29'h0123_4566, 4'h0, 64'h0, 1'h1, 1'h1);
        fr(1'h1, 1'h0, 29'h0123_4577, 4'h0, 64'h0, 1'h0, 1'h0);
        fr(1'h0, 1'h0, 29'h0123_4567, 4'h0, 64'h0, 1'h0, 1'h0);
        fr(1'h1, 1'h1, 29'h0123_4567, 4'h0, 64'h0, 1'h0, 1'h0);
        prog(32'h0123_4567, 32'h0, 64'h0, 32'h1fff_ffff, 64'h0, 32'h0);
        fr(1'h1, 1'h1, 29'h0123_4567, 4'h0, 64'h0, 1'h1, 1'h1);
        fr(1'h0, 1'h0, 29'h0122_b898, 4'h0, 64'h0, 1'h1, 1'h1);
        fr(1'h0, 1'h0, 29'h0127_4567, 4'h0, 64'h0, 1'h0, 1'h0);
        $display("test identifier done");
        for (int s = 0; s < 4; s++) begin
            rt(1'h0, 2'(s));
            rt(1'h1, 2'(s));
        end
        $display("test bounds done");
        // Length range with data checked, then scope without data
        prog(32'h0, 32'h0002_0005, 64'h1, 32'h0, 64'h0, 32'h15);
        fr(1'h1, 1'h0, 29'h5, 4'h1, 64'h1, 1'h0, 1'h0);
        fr(1'h1, 1'h0, 29'h5, 4'h2, 64'h1, 1'h1, 1'h1);
        fr(1'h1, 1'h0, 29'h5, 4'h5, 64'h1, 1'h1, 1'h1);
        fr(1'h1, 1'h0, 29'h5, 4'h6, 64'h1, 1'h0, 1'h0);
        fr(1'h1, 1'h0, 29'h5, 4'h3, 64'h0, 1'h0, 1'h0);
        prog(32'h0, 32'h0002_0005, 64'h1, 32'h0, 64'h0, 32'h14);
        fr(1'h1, 1'h0, 29'h5, 4'h9, 64'h0, 1'h1, 1'h1);
        // Counted scope: wake only on the third match
        prog(32'h0, 32'h0002_0005, 64'h1, 32'h0, 64'h0, 32'h0316);
        fr(1'h1, 1'h0, 29'h5, 4'h9, 64'h0, 1'h1, 1'h0);
        fr(1'h1, 1'h0, 29'h5, 4'h9, 64'h0, 1'h1, 1'h0);
        fr(1'h1, 1'h0, 29'h5, 4'h9, 64'h0, 1'h1, 1'h1);
        // Frozen clock enable swallows a frame that would match
        @(posedge clk_i);
        ce <= 1'h0;
        fr(1'h1, 1'h0, 29'h5, 4'h9, 64'h0, 1'h0, 1'h0);
        @(posedge clk_i);
        ce <= 1'h1;
        // Wake flag reads back set, then a written one clears it
        rd(cwf_pkg::CWF_OFF_STAT, 32'h0001_0000);
        wr(cwf_pkg::CWF_OFF_STAT, 32'h0001_0000);
        rd(cwf_pkg::CWF_OFF_STAT, 32'h0);
        $display("test scope done");
        test_done();
    end
endmodule : cwf_top_tb
